// >>> common/pfcd_defines.svh
`ifndef PFCD_DEFINES_SVH
`define PFCD_DEFINES_SVH
`define PFCD_CHAIN_DEPTH 43
`define PFCD_CODE_W 8
`define PFCD_PRIO_BIT 0
`define PFCD_END_MARK 8'h7F
`define PFCD_CLK_MHZ 25
`define PFCD_WINDOW_US 320
`define PFCD_WINDOW_CYC (`PFCD_WINDOW_US * `PFCD_CLK_MHZ)
`define PFCD_DEBOUNCE_CYC 250
`define PFCD_ADDR_STATUS 4'h0
`define PFCD_ADDR_MASK 4'h1
`define PFCD_ADDR_PRESENT 4'h2
`define PFCD_ADDR_PREVIOUS 4'h3
`define PFCD_ADDR_CTRL 4'h4
`define PFCD_EV_W 4
`define PFCD_EV_PWRCHK 0
`define PFCD_EV_THERMCHK 1
`define PFCD_EV_CAPDONE 2
`define PFCD_EV_SEARCH 3
`endif

// >>> common/pfcd_pkg.sv
package pfcd_pkg;
    typedef enum logic [2:0] {
        PFCD_IDLE = 3'b001,
        PFCD_CAPTURE = 3'b010,
        PFCD_HOLD = 3'b100
    } pfcd_state_e;
    typedef logic [7:0] pfcd_code_t;
endpackage : pfcd_pkg

// >>> rtl/pfcd_top.sv
// Notes on behaviour
// - fault chain holds at most 43 codes after a power check.
// - chain captures priority and additional codes only during 320 us window.
// - each search operation advances the chain by one entry until the 7F end marker shows.
// - present register reloads from chain output whenever the chain advances.
// - previous register copies present on power check or search if bit 0 set.
// - priority codes carry bit 0; additional codes name the failing supplies.
// - display shows 7F once no further codes remain to search.
// - search ignored unless system is off because of a power fault.
// - show-fault held shows latest, or preceding with prior-select up.
// - each search while show-fault held presents the next captured condition.
// - thermal trip lights thermal indicator; causes 2 to 7 light power check.
// - any shutdown condition or power switch off removes power enable.
// - lamp test lights control-supply status only if no fuse failed.
// - selected fault information drives display byte 0 via three switches.
//
// Design decisions made here: the address map and the plain strobed port.
`include "pfcd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pfcd_top #(
    parameter int DEPTH = `PFCD_CHAIN_DEPTH,
    parameter int WINDOW_CYC = `PFCD_WINDOW_CYC,
    parameter int DEBOUNCE_CYC = `PFCD_DEBOUNCE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_thermal_open,
    input wire logic i_overvoltage,
    input wire logic i_overcurrent,
    input wire logic i_undervoltage,
    input wire logic i_ac_loss,
    input wire logic i_emergency_off_switch,
    input wire logic i_card_missing,
    input wire logic i_cable_missing,
    input wire logic i_power_switch_off,
    input wire logic i_fuse_failed,
    input wire logic i_lamp_test,
    input wire logic i_code_valid,
    input wire logic [7:0] i_code,
    input wire logic i_show_fault,
    input wire logic i_prior_select,
    input wire logic i_search,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_power_on,
    output logic o_thermal_lamp,
    output logic o_power_check_lamp,
    output logic o_ctrl_supply_lamp,
    output logic [7:0] o_display,
    output logic o_irq
);
    localparam int PW = $clog2(DEPTH + 1);
    localparam int WW = $clog2(WINDOW_CYC + 1);
    localparam int DW = $clog2(DEBOUNCE_CYC + 1);

    // three-stage sync for all pin inputs
    localparam int NS = 15;
    logic [NS-1:0] pins;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] s3_r;
    logic [NS-1:0] q_r;
    assign pins = {i_thermal_open, i_overvoltage, i_overcurrent, i_undervoltage,
        i_ac_loss, i_emergency_off_switch, i_card_missing, i_cable_missing,
        i_power_switch_off, i_fuse_failed, i_lamp_test, i_code_valid,
        i_show_fault, i_prior_select, i_search};
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int k = 0; k < NS; k++) begin
                if (s2_r[k] == s3_r[k]) begin
                    q_r[k] <= s3_r[k];
                end
            end
        end
    end
    logic [7:0] code_s1_r;
    logic [7:0] code_s2_r;
    logic [7:0] code_s3_r;
    // code bus settles before its strobe clears the slower agree stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            code_s1_r <= '0;
            code_s2_r <= '0;
            code_s3_r <= '0;
        end else begin
            code_s1_r <= i_code;
            code_s2_r <= code_s1_r;
            code_s3_r <= code_s2_r;
        end
    end
    wire thermal = q_r[14];
    wire pfault = |q_r[13:8];
    wire misc_off = q_r[7] | q_r[6];
    wire power_sw_off = q_r[6];
    wire fuse_bad = q_r[5];
    wire lamp_test = q_r[4];
    wire code_vld = q_r[3];
    wire show = q_r[2];
    wire prior = q_r[1];
    wire search_db;
    logic [DW-1:0] db_cnt_r;
    logic search_st_r;
    logic search_prev_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            db_cnt_r <= '0;
            search_st_r <= 1'b0;
        end else if (q_r[0] == search_st_r) begin
            db_cnt_r <= '0;
        end else if (db_cnt_r == DW'(DEBOUNCE_CYC)) begin
            search_st_r <= q_r[0];
            db_cnt_r <= '0;
        end else begin
            db_cnt_r <= db_cnt_r + DW'(1);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            search_prev_r <= 1'b0;
        end else begin
            search_prev_r <= search_st_r;
        end
    end
    assign search_db = search_st_r & ~search_prev_r;

    logic pwr_fault_off_r;
    logic therm_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_power_on <= 1'b0;
            therm_r <= 1'b0;
            pwr_fault_off_r <= 1'b0;
        end else begin
            o_power_on <= ~(thermal | pfault | misc_off);
            if (thermal) begin
                therm_r <= 1'b1;
            end else if (power_sw_off) begin
                therm_r <= 1'b0;
            end
            if (pfault) begin
                pwr_fault_off_r <= 1'b1;
            end else if (power_sw_off) begin
                pwr_fault_off_r <= 1'b0;
            end
        end
    end
    wire pwr_check_rise = pfault & ~pwr_fault_off_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_thermal_lamp <= 1'b0;
            o_power_check_lamp <= 1'b0;
            o_ctrl_supply_lamp <= 1'b0;
        end else begin
            o_thermal_lamp <= therm_r | lamp_test;
            o_power_check_lamp <= pwr_fault_off_r | lamp_test;
            o_ctrl_supply_lamp <= lamp_test & ~fuse_bad;
        end
    end

    pfcd_pkg::pfcd_state_e st_r;
    logic [WW-1:0] win_cnt_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= pfcd_pkg::PFCD_IDLE;
            win_cnt_r <= '0;
        end else begin
            case (st_r)
                pfcd_pkg::PFCD_IDLE: begin
                    if (pwr_check_rise) begin
                        st_r <= pfcd_pkg::PFCD_CAPTURE;
                        win_cnt_r <= '0;
                    end
                end
                pfcd_pkg::PFCD_CAPTURE: begin
                    if (win_cnt_r == WW'(WINDOW_CYC - 1)) begin
                        st_r <= pfcd_pkg::PFCD_HOLD;
                    end else begin
                        win_cnt_r <= win_cnt_r + WW'(1);
                    end
                end
                pfcd_pkg::PFCD_HOLD: begin
                    if (!pwr_fault_off_r) begin
                        st_r <= pfcd_pkg::PFCD_IDLE;
                    end
                end
                default: st_r <= pfcd_pkg::PFCD_IDLE;
            endcase
        end
    end
    wire capturing = (st_r == pfcd_pkg::PFCD_CAPTURE);
    logic code_vld_d_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            code_vld_d_r <= 1'b0;
        end else begin
            code_vld_d_r <= code_vld;
        end
    end
    wire take_code = capturing & code_vld & ~code_vld_d_r;
    // search only while off for a power fault
    wire search_ok = search_db & show & pwr_fault_off_r & (st_r == pfcd_pkg::PFCD_HOLD);

    // chain storage as array with write and read pointers
    pfcd_pkg::pfcd_code_t chain_r [DEPTH];
    logic [PW-1:0] fill_r;
    logic [PW-1:0] rdp_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fill_r <= '0;
        end else if (pwr_check_rise) begin
            fill_r <= '0;
        end else if (take_code && fill_r != PW'(DEPTH)) begin
            chain_r[fill_r] <= code_s3_r;
            fill_r <= fill_r + PW'(1);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst || pwr_check_rise) begin
            rdp_r <= '0;
        end else if (search_ok && rdp_r != fill_r) begin
            rdp_r <= rdp_r + PW'(1);
        end
    end
    wire capture_end = capturing & (win_cnt_r == WW'(WINDOW_CYC - 1));

    // present reloads on advance; end marker when exhausted
    logic [7:0] present_r;
    logic [7:0] previous_r;
    wire [PW-1:0] nxt_idx = capture_end ? '0 : rdp_r + PW'(1);
    wire load_present = capture_end | (search_ok & rdp_r != fill_r);
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            present_r <= '0;
        end else if (load_present) begin
            present_r <= (nxt_idx < fill_r) ? chain_r[nxt_idx] : `PFCD_END_MARK;
        end
    end
    // previous copies priority code; bit 0 marks priority
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            previous_r <= '0;
        end else if ((pwr_check_rise | search_ok) && present_r[`PFCD_PRIO_BIT]) begin
            previous_r <= present_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_display <= '0;
        end else if (!show) begin
            o_display <= '0;
        end else begin
            o_display <= prior ? previous_r : present_r;
        end
    end

    // event status, mask, irq
    logic [3:0] stat_r;
    logic [3:0] mask_r;
    logic [3:0] ev;
    assign ev = {search_ok, capture_end, thermal & ~therm_r, pwr_check_rise};
    wire rd_stat = i_rd && i_addr == `PFCD_ADDR_STATUS;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= (rd_stat ? 4'h0 : stat_r) | ev;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mask_r <= '0;
        end else if (i_wr && i_addr == `PFCD_ADDR_MASK) begin
            mask_r <= i_wdata[3:0];
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_r & mask_r);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                `PFCD_ADDR_STATUS: o_rdata <= {4'h0, stat_r};
                `PFCD_ADDR_MASK: o_rdata <= {4'h0, mask_r};
                `PFCD_ADDR_PRESENT: o_rdata <= present_r;
                `PFCD_ADDR_PREVIOUS: o_rdata <= previous_r;
                `PFCD_ADDR_CTRL: o_rdata <= {5'h00, st_r};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // assertions
    a_power_off_cause: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (thermal | pfault) |=> !o_power_on)
        else $error("power stays on during fault");
    a_status_lamp: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (lamp_test & fuse_bad) |=> !o_ctrl_supply_lamp)
        else $error("status lamp lit with failed fuse");
    a_fill_bound: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fill_r <= PW'(DEPTH))
        else $error("chain overfilled");
    a_no_late_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (st_r == pfcd_pkg::PFCD_HOLD && !pwr_check_rise) |=> $stable(fill_r))
        else $error("capture after window");
    a_search_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!pwr_fault_off_r && !pwr_check_rise) |=> $stable(rdp_r))
        else $error("search advanced while not faulted");
    a_restart_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        pwr_check_rise |=> (rdp_r == '0 && fill_r == '0))
        else $error("new power check did not restart chain");
    a_search_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (search_ok && rdp_r != fill_r) |=> rdp_r == $past(rdp_r) + PW'(1))
        else $error("search did not advance by one");
    a_prev_prio: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(previous_r) |-> previous_r[`PFCD_PRIO_BIT])
        else $error("previous loaded non-priority");
    a_display_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (show && !prior) |=> o_display == $past(present_r))
        else $error("display not showing present");
    a_thermal_lamp: assert property (@(posedge i_core_clk) disable iff (i_rst)
        thermal |=> ##1 o_thermal_lamp)
        else $error("thermal lamp dark");
    c_capture: cover property (@(posedge i_core_clk) capture_end);
    c_search: cover property (@(posedge i_core_clk) search_ok);
    c_end_mark: cover property (@(posedge i_core_clk) present_r == `PFCD_END_MARK);
endmodule : pfcd_top
`default_nettype wire

// >>> verification/pfcd_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfcd_sense_model (
    input wire logic i_core_clk,
    input wire logic i_send,
    input wire logic [7:0] i_send_code,
    output logic o_code_valid,
    output logic [7:0] o_code
);
    logic [2:0] hold_r = 3'h0;
    logic [7:0] last_r = 8'h00;
    // strobe held five cycles so the pin synchroniser sees it settled
    always_ff @(posedge i_core_clk) begin
        if (i_send) begin
            last_r <= i_send_code;
            hold_r <= 3'h5;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end
    end
    assign o_code_valid = (hold_r != 3'h0);
    // released lines show the inverse, never a stale copy
    assign o_code = o_code_valid ? last_r : ~last_r;
endmodule : pfcd_sense_model
`default_nettype wire

// >>> verification/power_fault_capture_display_test.sv
`include "pfcd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module power_fault_capture_display_test;
    localparam int WIN = 500;
    localparam int DEB = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] cause = 9'h000;
    logic fuse = 1'b0, lamp = 1'b0, show = 1'b0, prior = 1'b0, srch = 1'b0;
    logic wr = 1'b0, rd = 1'b0, send = 1'b0, cv, pon, tl, pl, cl, irq;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, send_code = 8'h00, code, rdata, disp;
    int fails = 0, comparisons = 0, cyc = 0;
    always #20 clk = ~clk;
    pfcd_sense_model i_sense (.i_core_clk(clk), .i_send(send), .i_send_code(send_code),
        .o_code_valid(cv), .o_code(code));
    pfcd_top #(.WINDOW_CYC(WIN), .DEBOUNCE_CYC(DEB)) i_dut (
        .i_core_clk(clk), .i_rst(rst), .i_thermal_open(cause[0]), .i_overvoltage(cause[1]),
        .i_overcurrent(cause[2]), .i_undervoltage(cause[3]), .i_ac_loss(cause[4]),
        .i_emergency_off_switch(cause[5]), .i_card_missing(cause[6]),
        .i_cable_missing(cause[7]), .i_power_switch_off(cause[8]), .i_fuse_failed(fuse),
        .i_lamp_test(lamp), .i_code_valid(cv), .i_code(code), .i_show_fault(show),
        .i_prior_select(prior), .i_search(srch), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_power_on(pon), .o_thermal_lamp(tl),
        .o_power_check_lamp(pl), .o_ctrl_supply_lamp(cl), .o_display(disp), .o_irq(irq));
    function automatic logic [7:0] code_of(input int k);
        return 8'(k * 4 + ((k % 3 == 0) ? 1 : 0));
    endfunction : code_of
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : check_bit
    // ends just after an edge so registered outputs have landed
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read
    task automatic send_codes(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            send <= 1'b1;
            send_code <= code_of(k);
            @(posedge clk);
            send <= 1'b0;
            cycles(8);
        end
    endtask : send_codes
    task automatic press_search();
        @(posedge clk);
        srch <= 1'b1;
        cycles(DEB + 10);
        @(posedge clk);
        srch <= 1'b0;
        cycles(DEB + 10);
    endtask : press_search
    task automatic set_sw(input logic s, input logic p);
        @(posedge clk);
        show <= s;
        prior <= p;
        cycles(8);
    endtask : set_sw
    initial begin
        logic [7:0] d;
        logic [7:0] pres;
        logic [7:0] prev;
        cycles(10);
        @(posedge clk);
        rst <= 1'b0;
        cycles(10);
        check_bit("power on", 1'b1, pon);
        set_sw(1'b1, 1'b0);
        press_search();
        reg_read(`PFCD_ADDR_PRESENT, d);
        check_byte("present before fault", 8'h00, d);
        @(posedge clk);
        cause <= 9'h002;
        cycles(8);
        // 45 codes offered, two past the chain depth
        send_codes(45);
        cycles(80);
        check_bit("power on", 1'b0, pon);
        check_bit("power check lamp", 1'b1, pl);
        reg_read(`PFCD_ADDR_PRESENT, d);
        check_byte("present entry 0", code_of(0), d);
        check_byte("display latest", code_of(0), disp);
        pres = code_of(0);
        prev = 8'h00;
        for (int i = 1; i <= 43; i++) begin
            press_search();
            if (pres[0]) prev = pres;
            pres = (i < 43) ? code_of(i) : `PFCD_END_MARK;
            check_byte("display present", pres, disp);
            set_sw(1'b1, 1'b1);
            check_byte("display previous", prev, disp);
            set_sw(1'b1, 1'b0);
        end
        set_sw(1'b0, 1'b0);
        check_byte("display released", 8'h00, disp);
        reg_write(`PFCD_ADDR_PRESENT, 8'h55);
        reg_read(`PFCD_ADDR_PRESENT, d);
        check_byte("present read only", `PFCD_END_MARK, d);
        reg_read(4'hF, d);
        check_byte("unmapped read", 8'h00, d);
        reg_read(`PFCD_ADDR_PREVIOUS, d);
        check_byte("previous register", prev, d);
        reg_read(`PFCD_ADDR_CTRL, d);
        check_byte("state register", 8'(pfcd_pkg::PFCD_HOLD), d);
        reg_read(`PFCD_ADDR_STATUS, d);
        check_bit("status power check", 1'b1, d[`PFCD_EV_PWRCHK]);
        reg_write(`PFCD_ADDR_MASK, 8'h0F);
        reg_read(`PFCD_ADDR_MASK, d);
        check_byte("mask", 8'h0F, d);
        check_bit("irq after clear", 1'b0, irq);
        for (int c = 0; c < 9; c++) begin
            @(posedge clk);
            cause <= 9'h100;
            cycles(10);
            @(posedge clk);
            cause <= 9'h000;
            cycles(10);
            reg_read(`PFCD_ADDR_STATUS, d);
            check_bit("power on clear", 1'b1, pon);
            @(posedge clk);
            cause <= 9'(1 << c);
            cycles(WIN + 20);
            check_bit("power on", 1'b0, pon);
            check_bit("thermal lamp", c == 0, tl);
            check_bit("power check lamp", c >= 1 && c <= 6, pl);
            if (c == 1) begin
                check_bit("irq raised", 1'b1, irq);
                reg_write(`PFCD_ADDR_MASK, 8'h00);
                cycles(3);
                check_bit("irq masked", 1'b0, irq);
            end
        end
        for (int t = 0; t < 4; t++) begin
            @(posedge clk);
            lamp <= t[0];
            fuse <= t[1];
            cycles(8);
            check_bit("ctrl supply lamp", t[0] & ~t[1], cl);
        end
        tally_and_finish();
    end
endmodule : power_fault_capture_display_test
`default_nettype wire
